/* shared/slbc_pkg.sv */
package slbc_pkg;
	// clock rate
	localparam int unsigned CLK_HZ            = 10_000_000;
	localparam int unsigned CLK_NS            = 100;
	// printed times
	localparam int unsigned SELF_TEST_MS      = 80;
	localparam int unsigned LIT_HOLD_S        = 20;
	localparam int unsigned SOFT_START_MS     = 9;
	localparam int unsigned SHORT_DELAY_US    = 500;
	localparam int unsigned BLANK_NS          = 600;
	localparam int unsigned OFF_MIN_US        = 3;
	localparam int unsigned OFF_MAX_US        = 35;
	localparam int unsigned ON_MIN_US         = 1;
	// derived cycle counts (least times round up, longest round down)
	localparam int unsigned SELF_TEST_CYC     = SELF_TEST_MS * (CLK_HZ / 1000);
	localparam int unsigned LIT_HOLD_CYC      = LIT_HOLD_S * CLK_HZ;
	localparam int unsigned SOFT_START_CYC    = SOFT_START_MS * (CLK_HZ / 1000);
	localparam int unsigned SHORT_DELAY_CYC   = SHORT_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int unsigned BLANK_CYC         = (BLANK_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned OFF_MIN_CYC       = OFF_MIN_US * (CLK_HZ / 1_000_000);
	localparam int unsigned OFF_MAX_CYC       = OFF_MAX_US * (CLK_HZ / 1_000_000);
	localparam int unsigned ON_MIN_CYC        = ON_MIN_US * (CLK_HZ / 1_000_000);
	// counter widths
	localparam int unsigned LONG_W            = 28;
	localparam int unsigned SW_W              = 10;
	localparam int unsigned RAMP_W            = 8;
	localparam int unsigned DERATE_W          = 4;
	// soft start: extra off-time added at the start of the ramp, in cycles
	localparam logic [RAMP_W-1:0] RAMP_START  = 8'hFF;
	// thermal derating: cycles between steps of the off-time trim
	localparam int unsigned DERATE_STEP_CYC   = 10_000;
	localparam logic [DERATE_W-1:0] DERATE_MAX = 4'hF;

	typedef enum logic [2:0] {
		SLBC_OFF,
		SLBC_SELFTEST,
		SLBC_STANDBY,
		SLBC_LIT,
		SLBC_RESTART,
		SLBC_LOCKED
	} slbc_mode_e;

	typedef enum logic [1:0] {
		SLBC_SW_IDLE,
		SLBC_SW_ON,
		SLBC_SW_OFF
	} slbc_sw_e;
endpackage

/* src/slbc_switch.sv */
// hysteretic peak/valley switch timing with blanking and on/off limits
module slbc_switch (
	// clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic                           clkEn,
	// control
	input  wire logic                           run,
	input  wire logic [slbc_pkg::RAMP_W-1:0]    extraOff,
	input  wire logic [slbc_pkg::DERATE_W-1:0]  peakTrim,
	// synchronised comparators
	input  wire logic                           peakHit,
	input  wire logic                           valleyHit,
	// gate drive
	output logic                                gateOn
);
	slbc_pkg::slbc_sw_e           state_r;
	logic [slbc_pkg::SW_W-1:0]    cnt_r;
	logic                         blanked;
	logic                         offDone;

	// comparators are ignored right after turn-on
	assign blanked = (cnt_r < slbc_pkg::SW_W'(slbc_pkg::BLANK_CYC));
	// the soft start and derating stretch the minimum off time; a bounded cap keeps the valley timeout valid
	assign offDone = (cnt_r >= slbc_pkg::SW_W'(slbc_pkg::OFF_MIN_CYC) + slbc_pkg::SW_W'(extraOff)
		+ slbc_pkg::SW_W'(peakTrim)) && valleyHit;

	// switch sequencer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= slbc_pkg::SLBC_SW_IDLE;
			cnt_r   <= '0;
			gateOn  <= 1'b0;
		end
		else if (clkEn)
		begin
			if (!run)
			begin
				state_r <= slbc_pkg::SLBC_SW_IDLE;
				cnt_r   <= '0;
				gateOn  <= 1'b0;
			end
			else
			begin
				case (state_r)
					slbc_pkg::SLBC_SW_IDLE:
					begin
						// a fresh start or a quick mode change still honours the minimum off time
						if (cnt_r >= slbc_pkg::SW_W'(slbc_pkg::OFF_MIN_CYC))
						begin
							state_r <= slbc_pkg::SLBC_SW_ON;
							cnt_r   <= '0;
							gateOn  <= 1'b1;
						end
						else
							cnt_r <= cnt_r + 1'b1;
					end
					slbc_pkg::SLBC_SW_ON:
					begin
						// peak only counts after blanking and the minimum on time
						if (!blanked && cnt_r >= slbc_pkg::SW_W'(slbc_pkg::ON_MIN_CYC) && peakHit)
						begin
							state_r <= slbc_pkg::SLBC_SW_OFF;
							cnt_r   <= '0;
							gateOn  <= 1'b0;
						end
						else
							cnt_r <= cnt_r + 1'b1;
					end
					slbc_pkg::SLBC_SW_OFF:
					begin
						if (offDone || cnt_r >= slbc_pkg::SW_W'(slbc_pkg::OFF_MAX_CYC - 1))
						begin
							state_r <= slbc_pkg::SLBC_SW_ON;
							cnt_r   <= '0;
							gateOn  <= 1'b1;
						end
						else
							cnt_r <= cnt_r + 1'b1;
					end
					default:
					begin
						state_r <= slbc_pkg::SLBC_SW_IDLE;
						gateOn  <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule // slbc_switch

/* src/slbc_control.sv */
// Summary of operation
// - supply reaching start level starts the device in self-test
// - supply below stop level locks out everything until start level returns
// - soft start ramps switching frequency up from minimum over 9 ms
// - self-test lasts 80 ms with the LEDs on
// - after self-test LEDs go off and standby watches sound and light
// - bright light (below low level) disables sound detection
// - dark light (above high level) enables sound detection
// - enabled sound trigger lights LEDs for 20 s then returns to standby
// - sound input held high makes the light input alone govern the LEDs
// - current-sense results ignored for 600 ns after each turn-on
// - over-temperature lowers output current gradually, no abrupt shutdown
// - open current-sense turns switch off, auto-restart when fault clears
// - short circuit lasting 500 us turns switch off and latches locked mode
// - locked mode leaves only through lockout and a fresh start
// - switch on, off at peak, back on at valley
// - switch off at least 3 us each cycle
// - off time reaching 35 us forces the next turn-on
// - switch on at least 1 us before peak may turn it off
module slbc_control #(
	parameter int unsigned SELF_TEST_CYC   = slbc_pkg::SELF_TEST_CYC,
	parameter int unsigned LIT_HOLD_CYC    = slbc_pkg::LIT_HOLD_CYC,
	parameter int unsigned SOFT_START_CYC  = slbc_pkg::SOFT_START_CYC,
	parameter int unsigned DERATE_STEP_CYC = slbc_pkg::DERATE_STEP_CYC
) (
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire logic  clkEn,
	// supply comparators
	input  wire logic  supplyAboveStart,
	input  wire logic  supplyBelowStop,
	// sensing comparators
	input  wire logic  lightAboveHigh,
	input  wire logic  lightBelowLow,
	input  wire logic  soundAboveTrigger,
	// current-sense and protection comparators
	input  wire logic  peakHit,
	input  wire logic  valleyHit,
	input  wire logic  senseOpen,
	input  wire logic  outputShort,
	input  wire logic  overTemp,
	// outputs
	output logic       gateOn,
	output logic       ledsOn,
	output logic       locked,
	output logic       derating
);
	localparam int unsigned NIN = 10;

	logic [NIN-1:0]                syncA_r;
	logic [NIN-1:0]                syncB_r;
	logic [NIN-1:0]                rawIn;
	logic                          sAbove, sBelow, lHigh, lLow, snd, pk, vl, sOpen, sShort, hot;
	slbc_pkg::slbc_mode_e          mode_r;
	logic [slbc_pkg::LONG_W-1:0]   timer_r;
	logic [slbc_pkg::LONG_W-1:0]   ssCnt_r;
	logic [slbc_pkg::LONG_W-1:0]   shortCnt_r;
	logic [slbc_pkg::LONG_W-1:0]   derCnt_r;
	logic [slbc_pkg::RAMP_W-1:0]   extraOff_r;
	logic [slbc_pkg::DERATE_W-1:0] trim_r;
	logic                          soundEn_r;
	logic                          run;
	logic                          swGate;

	// pins cross in from the analog side through two flops each
	assign rawIn = {overTemp, outputShort, senseOpen, valleyHit, peakHit,
		soundAboveTrigger, lightBelowLow, lightAboveHigh, supplyBelowStop, supplyAboveStart};

	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++)
		begin : g_sync
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					syncA_r[gi] <= 1'b0;
					syncB_r[gi] <= 1'b0;
				end
				else if (clkEn)
				begin
					syncA_r[gi] <= rawIn[gi];
					syncB_r[gi] <= syncA_r[gi];
				end
			end
		end
	endgenerate

	assign {hot, sShort, sOpen, vl, pk, snd, lLow, lHigh, sBelow, sAbove} = syncB_r;

	// true while a timed mode has run its course
	function automatic logic expired(input logic [slbc_pkg::LONG_W-1:0] t, input int unsigned lim);
		expired = (t >= slbc_pkg::LONG_W'(lim - 1));
	endfunction

	// operating mode sequencer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_r  <= slbc_pkg::SLBC_OFF;
			timer_r <= '0;
		end
		else if (clkEn)
		begin
			timer_r <= timer_r + 1'b1;
			if (sBelow && mode_r != slbc_pkg::SLBC_OFF)
			begin
				mode_r  <= slbc_pkg::SLBC_OFF;
				timer_r <= '0;
			end
			else
			begin
				case (mode_r)
					slbc_pkg::SLBC_OFF:
					begin
						timer_r <= '0;
						if (sAbove)
							mode_r <= slbc_pkg::SLBC_SELFTEST;
					end
					slbc_pkg::SLBC_SELFTEST:
						if (expired(timer_r, SELF_TEST_CYC))
						begin
							mode_r  <= slbc_pkg::SLBC_STANDBY;
							timer_r <= '0;
						end
					slbc_pkg::SLBC_STANDBY:
					begin
						timer_r <= '0;
						// a permanently high sound input fires as soon as darkness enables detection
						if (soundEn_r && snd)
							mode_r <= slbc_pkg::SLBC_LIT;
					end
					slbc_pkg::SLBC_LIT:
						if (expired(timer_r, LIT_HOLD_CYC))
						begin
							mode_r  <= slbc_pkg::SLBC_STANDBY;
							timer_r <= '0;
						end
					slbc_pkg::SLBC_RESTART:
					begin
						timer_r <= '0;
						if (!sOpen)
							mode_r <= slbc_pkg::SLBC_SELFTEST;
					end
					slbc_pkg::SLBC_LOCKED:
						timer_r <= '0;
					default:
						mode_r <= slbc_pkg::SLBC_OFF;
				endcase
				// protection overrides the lit modes
				if (mode_r == slbc_pkg::SLBC_SELFTEST || mode_r == slbc_pkg::SLBC_LIT)
				begin
					if (expired(shortCnt_r, slbc_pkg::SHORT_DELAY_CYC))
						mode_r <= slbc_pkg::SLBC_LOCKED;
					else if (sOpen)
						mode_r <= slbc_pkg::SLBC_RESTART;
				end
			end
		end
	end

	// sound detection enable with hysteresis on the light input
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			soundEn_r <= 1'b0;
		else if (clkEn)
		begin
			if (lLow)
				soundEn_r <= 1'b0;
			else if (lHigh)
				soundEn_r <= 1'b1;
			// otherwise hold
		end
	end

	assign run = (mode_r == slbc_pkg::SLBC_SELFTEST || mode_r == slbc_pkg::SLBC_LIT);

	// short-circuit persistence counter, cleared as soon as the short goes away
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			shortCnt_r <= '0;
		else if (clkEn)
		begin
			if (run && sShort)
				shortCnt_r <= shortCnt_r + 1'b1;
			else
				shortCnt_r <= '0;
		end
	end

	// soft start: extra off time shrinks linearly, so frequency rises from its minimum
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ssCnt_r    <= '0;
			extraOff_r <= slbc_pkg::RAMP_START;
		end
		else if (clkEn)
		begin
			if (!run)
			begin
				ssCnt_r    <= '0;
				extraOff_r <= slbc_pkg::RAMP_START;
			end
			else if (extraOff_r != '0)
			begin
				// one step per ramp slice, spread over the whole soft start
				if (expired(ssCnt_r, SOFT_START_CYC >> slbc_pkg::RAMP_W))
				begin
					ssCnt_r    <= '0;
					extraOff_r <= extraOff_r - 1'b1;
				end
				else
					ssCnt_r <= ssCnt_r + 1'b1;
			end
		end
	end

	// thermal derating: stretch off time stepwise while hot, relax when cool
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			derCnt_r <= '0;
			trim_r   <= '0;
		end
		else if (clkEn)
		begin
			if (expired(derCnt_r, DERATE_STEP_CYC))
			begin
				derCnt_r <= '0;
				if (hot && trim_r != slbc_pkg::DERATE_MAX)
					trim_r <= trim_r + 1'b1;
				else if (!hot && trim_r != '0)
					trim_r <= trim_r - 1'b1;
			end
			else
				derCnt_r <= derCnt_r + 1'b1;
		end
	end

	slbc_switch u_switch (
		.clk       (clk),
		.rst_n     (rst_n),
		.clkEn     (clkEn),
		.run       (run),
		.extraOff  (extraOff_r),
		.peakTrim  (trim_r),
		.peakHit   (pk),
		.valleyHit (vl),
		.gateOn    (swGate)
	);

	// registered outputs; gate is re-timed and killed at once when leaving a running mode
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gateOn   <= 1'b0;
			ledsOn   <= 1'b0;
			locked   <= 1'b0;
			derating <= 1'b0;
		end
		else if (clkEn)
		begin
			gateOn   <= swGate && run;
			ledsOn   <= run;
			locked   <= (mode_r == slbc_pkg::SLBC_LOCKED);
			derating <= (trim_r != '0);
		end
	end
endmodule // slbc_control

/* test/slbc_load.sv */
// inductor, current comparators and LED string seen from the switch
module slbc_load (
	// clock and pace
	input  wire logic clk,
	input  wire logic slow,
	// power switch
	input  wire logic gateOn,
	// comparator levels
	output logic      peakHit,
	output logic      valleyHit
);
	timeunit 1ns;
	timeprecision 1ns;
	int amps = 0;
	// current climbs while the switch conducts, decays while it is off; slow means a low bus voltage
	always @(posedge clk)
		if (gateOn)
			amps <= amps + (slow ? 1 : 4);
		else if (amps > 0)
			amps <= amps - 1;
	// peak and valley references as fixed levels
	assign peakHit   = amps >= 60;
	assign valleyHit = amps <= 20;
endmodule // slbc_load

/* test/slbc_control_properties.sv */
module slbc_control_properties #(
	parameter int unsigned DERATE_STEP_CYC = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// comparators
	input wire logic supplyAboveStart,
	input wire logic supplyBelowStop,
	input wire logic lightAboveHigh,
	input wire logic lightBelowLow,
	input wire logic soundAboveTrigger,
	input wire logic peakHit,
	input wire logic valleyHit,
	input wire logic senseOpen,
	input wire logic outputShort,
	input wire logic overTemp,
	// outputs
	input wire logic gateOn,
	input wire logic ledsOn,
	input wire logic locked,
	input wire logic derating
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic [12:0] offCnt_r;
	logic [12:0] offLit_r;
	logic [12:0] shortCnt_r;
	logic [12:0] heatCnt_r;
	// run lengths saturate so that long idle spells never wrap to zero
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			offCnt_r   <= '0;
			offLit_r   <= '0;
			shortCnt_r <= '0;
			heatCnt_r  <= '0;
		end
		else
		begin
			offCnt_r   <= gateOn ? '0 : offCnt_r + 13'(offCnt_r != '1);
			offLit_r   <= (gateOn || !ledsOn) ? '0 : offLit_r + 13'(offLit_r != '1);
			shortCnt_r <= !outputShort ? '0 : shortCnt_r + 13'(shortCnt_r != '1);
			heatCnt_r  <= !(overTemp && ledsOn) ? '0 : heatCnt_r + 13'(heatCnt_r != '1);
		end
	a_start_selftest: assert property ($rose(supplyAboveStart) && !supplyBelowStop |-> ##[3:5] ledsOn)
		else $error("no self-test after supply rise");
	a_stop_lockout: assert property (supplyBelowStop [*6] |-> !ledsOn && !gateOn && !locked)
		else $error("activity under lockout");
	a_on_min: assert property ($rose(gateOn) |-> (gateOn || !ledsOn) [*8])
		else $error("on time too short");
	a_off_min: assert property ($rose(gateOn) |-> offCnt_r >= 13'h001E)
		else $error("off time too short");
	a_off_max: assert property (offLit_r <= 13'h0160)
		else $error("off time too long");
	a_open_off: assert property (senseOpen [*6] |-> !gateOn && !ledsOn)
		else $error("switching with open sense");
	a_locked_off: assert property (locked ##1 locked |-> !gateOn && !ledsOn)
		else $error("switching while locked");
	a_short_late: assert property (shortCnt_r >= 13'h1392 |-> locked)
		else $error("short did not lock");
	a_short_early: assert property ($rose(locked) |-> shortCnt_r >= 13'h1383)
		else $error("locked too early");
	a_bright_dark: assert property ((lightBelowLow && supplyAboveStart && !senseOpen && !ledsOn) [*6] |=> !ledsOn)
		else $error("lit in bright light");
	a_heat_derate: assert property (heatCnt_r == 13'(DERATE_STEP_CYC * 2 + 4) |-> derating)
		else $error("no derating when hot");
endmodule // slbc_control_properties

bind slbc_control slbc_control_properties #(.DERATE_STEP_CYC(DERATE_STEP_CYC)) i_props (
	.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .supplyAboveStart(supplyAboveStart),
	.supplyBelowStop(supplyBelowStop), .lightAboveHigh(lightAboveHigh), .lightBelowLow(lightBelowLow),
	.soundAboveTrigger(soundAboveTrigger), .peakHit(peakHit), .valleyHit(valleyHit), .senseOpen(senseOpen),
	.outputShort(outputShort), .overTemp(overTemp), .gateOn(gateOn), .ledsOn(ledsOn), .locked(locked),
	.derating(derating)
);

/* test/sound_light_led_buck_control_tb.sv */
module sound_light_led_buck_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned TEST_CYC = 6000;
	localparam int unsigned LIT_CYC  = 300;
	logic clk = 0, rst_n = 0, clkEn = 1, slow = 0;
	logic supplyAboveStart = 0, supplyBelowStop = 1, lightAboveHigh = 0, lightBelowLow = 1;
	logic soundAboveTrigger = 0, senseOpen = 0, outputShort = 0, overTemp = 0;
	logic peakHit, valleyHit, gateOn, ledsOn, locked, derating, gatePrev = 0;
	int failures = 0, cmp_count = 0, cycles = 0, runLen = 0, expLen, gateRises = 0;
	int seed = 32'h8cc1ba41;
	int lens[$];
	initial
	begin
		forever #50 clk = ~clk;
	end
	slbc_control #(.SELF_TEST_CYC(TEST_CYC), .LIT_HOLD_CYC(LIT_CYC), .SOFT_START_CYC(512), .DERATE_STEP_CYC(8)) i_dut (
		.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .supplyAboveStart(supplyAboveStart),
		.supplyBelowStop(supplyBelowStop), .lightAboveHigh(lightAboveHigh), .lightBelowLow(lightBelowLow),
		.soundAboveTrigger(soundAboveTrigger), .peakHit(peakHit), .valleyHit(valleyHit), .senseOpen(senseOpen),
		.outputShort(outputShort), .overTemp(overTemp), .gateOn(gateOn), .ledsOn(ledsOn), .locked(locked),
		.derating(derating)
	);
	slbc_load i_load (.clk(clk), .slow(slow), .gateOn(gateOn), .peakHit(peakHit), .valleyHit(valleyHit));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask
	task automatic chkBit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %0t flag %b not %b", $time, got, exp);
		end
	endtask
	task automatic chkLen(input int got, input int exp);
		cmp_count++;
		if (got != exp)
		begin
			failures++;
			$display("BAD %0t length %0d not %0d", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		chkLen(lens.size(), 0);
		if (failures == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// supply step; the load pace is drawn anew at every power-up
	task automatic supply(input logic up);
		supplyAboveStart = up;
		supplyBelowStop = !up;
		slow = 1'($random(seed));
		tick(8);
	endtask
	// sound burst of random width, long enough to pass the synchroniser
	task automatic ping();
		soundAboveTrigger = 1;
		tick(3 + ($unsigned($random(seed)) % 6));
		soundAboveTrigger = 0;
		tick(6);
	endtask
	task automatic untilOff();
		int n;
		n = 0;
		while (ledsOn !== 1'b0 && n < 8000)
		begin
			tick(1);
			n++;
		end
	endtask
	// every LED spell is matched against the oldest note; a zero note is a spell cut short on purpose
	always @(posedge clk)
	begin
		gateRises += int'(gateOn === 1'b1 && !gatePrev);
		gatePrev = gateOn;
		if (ledsOn === 1'b1)
			runLen++;
		else if (runLen != 0)
		begin
			expLen = lens.size() ? lens.pop_front() : -1;
			if (expLen != 0)
				chkLen(runLen, expLen);
			runLen = 0;
		end
	end
	// hang guard: the sequence needs about 24000 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			failures++;
			end_of_test();
		end
	end
	initial
	begin
		tick(12);
		rst_n = 1;
		tick(2);
		lens.push_back(TEST_CYC);
		overTemp = 1;
		supply(1);
		tick(60);
		chkBit(derating, 1);
		chkBit(ledsOn, 1);
		overTemp = 0;
		untilOff();
		chkBit(gateRises > 2, 1);
		ping();
		chkBit(ledsOn, 0);
		lightBelowLow = 0;
		lightAboveHigh = 1;
		tick(6);
		lightAboveHigh = 0;
		tick(4);
		lens.push_back(LIT_CYC);
		ping();
		chkBit(ledsOn, 1);
		ping();
		untilOff();
		// a frozen clock enable must not let a sound burst through
		clkEn = 0;
		ping();
		chkBit(ledsOn, 0);
		clkEn = 1;
		lightBelowLow = 1;
		tick(6);
		lightBelowLow = 0;
		ping();
		chkBit(ledsOn, 0);
		// sound held high: the light level alone decides
		soundAboveTrigger = 1;
		tick(20);
		chkBit(ledsOn, 0);
		lens.push_back(LIT_CYC);
		lens.push_back(LIT_CYC);
		lightAboveHigh = 1;
		tick(8);
		lightAboveHigh = 0;
		chkBit(ledsOn, 1);
		untilOff();
		tick(6);
		chkBit(ledsOn, 1);
		soundAboveTrigger = 0;
		untilOff();
		lightBelowLow = 1;
		// open sense connection in self-test, then recovery
		supply(0);
		lens.push_back(0);
		supply(1);
		tick(36);
		senseOpen = 1;
		tick(8);
		chkBit(gateOn, 0);
		chkBit(ledsOn, 0);
		lens.push_back(TEST_CYC);
		senseOpen = 0;
		tick(8);
		chkBit(ledsOn, 1);
		untilOff();
		// lasting short latches until the supply is cycled
		supply(0);
		lens.push_back(0);
		supply(1);
		outputShort = 1;
		tick(5100);
		chkBit(locked, 1);
		chkBit(gateOn, 0);
		outputShort = 0;
		tick(50);
		chkBit(locked, 1);
		supply(0);
		chkBit(locked, 0);
		lens.push_back(TEST_CYC);
		supply(1);
		untilOff();
		// let the watcher close the last spell before the queue is checked
		tick(2);
		end_of_test();
	end
endmodule // sound_light_led_buck_control_tb
